// >>> rtl/osad_decode.sv
// module: setup-mode option bytes and host address window decode
module osad_decode #(
  // arbitrary neutral value, replace with the allocated identifier
  parameter logic [15:0] ADAPTER_IDENTIFIER = 16'h5A31
) (
  // clock and reset
  input  wire logic                              sys_clk_i,
  input  wire logic                              resetn_i,
  // host i/o cycle
  input  wire logic [osad_pkg::OSAD_IO_AW-1:0]   io_addr_i,
  input  wire logic                              io_wr_i,
  input  wire logic                              io_rd_i,
  input  wire logic [osad_pkg::OSAD_DW-1:0]      io_wdata_i,
  output logic      [osad_pkg::OSAD_DW-1:0]      io_rdata_o,
  output logic                                   io_rvalid_o,
  output logic                                   io_block_hit_o,
  // host memory cycle
  input  wire logic [osad_pkg::OSAD_MEM_AW-1:0]  mem_addr_i,
  input  wire logic                              mem_cyc_i,
  output logic                                   rom_hit_o,
  output logic                                   cop_hit_o,
  output logic                                   ap4_hit_o,
  output logic                                   ap1_hit_o,
  // computed bases and mode
  output logic                                   setup_mode_o,
  output logic      [osad_pkg::OSAD_MEM_AW-1:0]  rom_base_o,
  output logic      [osad_pkg::OSAD_MEM_AW-1:0]  cop_base_o,
  output logic      [osad_pkg::OSAD_IO_AW-1:0]   io_base_o,
  output logic      [osad_pkg::OSAD_MEM_AW-1:0]  vmem_base_o,
  output logic      [osad_pkg::OSAD_MEM_AW-1:0]  ap1_base_o
);
  import osad_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                   setup;
    logic [7:0]             rom_inst;
    logic [7:0]             vmem;
    logic [7:0]             small_ap;
    logic [OSAD_DW-1:0]     rdata;
    logic                   rvalid;
    logic                   io_hit;
    logic                   rom_hit;
    logic                   cop_hit;
    logic                   ap4_hit;
    logic                   ap1_hit;
    logic [OSAD_MEM_AW-1:0] rom_base;
    logic [OSAD_MEM_AW-1:0] cop_base;
    logic [OSAD_IO_AW-1:0]  io_base;
    logic [OSAD_MEM_AW-1:0] vmem_base;
    logic [OSAD_MEM_AW-1:0] ap1_base;
  } osad_state_t;

  osad_state_t st_r;
  osad_state_t st_nxt;

  // ----------------------------------------------------------------------
  // field extraction and base arithmetic on the stored bytes
  // ----------------------------------------------------------------------
  logic [3:0]             rom_field;
  logic [2:0]             inst;
  logic [6:0]             vmem_field;
  logic                   ap4_en;
  logic [3:0]             ap1_field;
  logic [OSAD_MEM_AW-1:0] rom_base;
  logic [OSAD_MEM_AW-1:0] cop_base;
  logic [OSAD_IO_AW-1:0]  io_base;
  logic [OSAD_MEM_AW-1:0] vmem_base;
  logic [OSAD_MEM_AW-1:0] ap1_base;

  assign rom_field  = st_r.rom_inst[OSAD_ROM_FIELD_LSB +: 4];
  assign inst       = st_r.rom_inst[OSAD_INST_LSB +: 3];
  assign vmem_field = st_r.vmem[OSAD_VMEM_FIELD_LSB +: 7];
  assign ap4_en     = st_r.vmem[OSAD_AP4_EN_BIT];
  assign ap1_field  = st_r.small_ap[OSAD_AP1_FIELD_LSB +: 4];

  // 8KB steps above 0C0000h
  assign rom_base = OSAD_ROM_OFFSET + (32'(rom_field) << OSAD_ROM_STEP_LSB);
  // 128-byte register window per instance inside the rom window
  assign cop_base = rom_base + OSAD_COP_OFFSET + (32'(inst) << OSAD_COP_STEP_LSB);
  assign io_base  = {OSAD_IO_PREFIX, 1'b0, inst, 4'h0};
  // 32MB region from the field, 4MB slot from the instance
  assign vmem_base = (32'(vmem_field) << OSAD_VMEM_REGION_LSB)
                   | (32'(inst) << OSAD_VMEM_SLOT_LSB);
  assign ap1_base = 32'(ap1_field) << OSAD_AP1_STEP_LSB;

  // ----------------------------------------------------------------------
  // host cycle qualification
  // ----------------------------------------------------------------------
  logic        pos_sel;
  logic [2:0]  pos_off;
  logic        board_port;
  logic        io_cyc;

  assign pos_sel    = (io_addr_i[OSAD_IO_AW-1:3] == OSAD_POS_BASE[OSAD_IO_AW-1:3]);
  assign pos_off    = io_addr_i[2:0];
  assign board_port = (io_addr_i == OSAD_BOARD_SETUP_PORT);
  assign io_cyc     = io_wr_i | io_rd_i;

  // ----------------------------------------------------------------------
  // host strobes
  // ----------------------------------------------------------------------
  logic board_wr;
  logic opt_wr;
  logic opt_rd;
  logic win_open;

  // option bytes listen only in setup mode, windows only outside it
  assign board_wr = io_wr_i & board_port;
  assign opt_wr   = io_wr_i & st_r.setup & pos_sel;
  assign opt_rd   = io_rd_i & st_r.setup & pos_sel;
  // dark windows in setup mode keep config probes from colliding with them
  assign win_open = ~st_r.setup;

  // ----------------------------------------------------------------------
  // window address compares
  // ----------------------------------------------------------------------
  // compares use the live bases, so a hit follows a byte write one edge later
  logic io_match;
  logic rom_match;
  logic cop_match;
  logic ap4_match;
  logic ap1_match;
  logic ap1_on;

  // 16-port block, low nibble selects the register
  assign io_match  = (io_addr_i[OSAD_IO_AW-1:OSAD_IO_BLOCK_LSB]
                      == io_base[OSAD_IO_AW-1:OSAD_IO_BLOCK_LSB]);
  // 8KB rom window
  assign rom_match = (mem_addr_i[OSAD_MEM_AW-1:OSAD_ROM_STEP_LSB]
                      == rom_base[OSAD_MEM_AW-1:OSAD_ROM_STEP_LSB]);
  // 128-byte coprocessor window, always inside the rom window
  assign cop_match = (mem_addr_i[OSAD_MEM_AW-1:OSAD_COP_STEP_LSB]
                      == cop_base[OSAD_MEM_AW-1:OSAD_COP_STEP_LSB]);
  // full 4MB compare: every video memory byte is reachable through it
  assign ap4_match = (mem_addr_i[OSAD_MEM_AW-1:OSAD_VMEM_SLOT_LSB]
                      == vmem_base[OSAD_MEM_AW-1:OSAD_VMEM_SLOT_LSB]);
  assign ap1_match = (mem_addr_i[OSAD_MEM_AW-1:OSAD_AP1_STEP_LSB]
                      == ap1_base[OSAD_MEM_AW-1:OSAD_AP1_STEP_LSB]);
  // a zero field would alias the bottom megabyte, so it switches the aperture off
  assign ap1_on    = (ap1_field != 4'h0);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // bases are republished every cycle so they trail a byte write by one edge
    st_nxt.rom_base  = rom_base;
    st_nxt.cop_base  = cop_base;
    st_nxt.io_base   = io_base;
    st_nxt.vmem_base = vmem_base;
    st_nxt.ap1_base  = ap1_base;

    // setup control port, any other value leaves the mode alone
    if (board_wr) begin
      if (io_wdata_i == OSAD_BOARD_SETUP_VAL) begin
        st_nxt.setup = 1'b1;
      end else if (io_wdata_i == OSAD_BOARD_ENABLE_VAL) begin
        st_nxt.setup = 1'b0;
      end
    end

    // option bytes are writable only in setup mode; reserved bits are kept as written
    if (opt_wr) begin
      unique case (pos_off)
        OSAD_POS_ROM_INST: begin
          st_nxt.rom_inst = io_wdata_i;
        end
        OSAD_POS_VMEM: begin
          st_nxt.vmem = io_wdata_i;
        end
        OSAD_POS_SMALL_AP: begin
          st_nxt.small_ap = io_wdata_i;
        end
        default: begin
        end
      endcase
    end

    // setup reads answer one edge later; unused offsets read as zero
    st_nxt.rvalid = 1'b0;
    st_nxt.rdata  = '0;
    if (opt_rd) begin
      st_nxt.rvalid = 1'b1;
      unique case (pos_off)
        OSAD_ADAPTER_IDENTIFIER_LO: begin
          st_nxt.rdata = ADAPTER_IDENTIFIER[7:0];
        end
        OSAD_ADAPTER_IDENTIFIER_HI: begin
          st_nxt.rdata = ADAPTER_IDENTIFIER[15:8];
        end
        OSAD_POS_ROM_INST: begin
          st_nxt.rdata = st_r.rom_inst;
        end
        OSAD_POS_VMEM: begin
          st_nxt.rdata = st_r.vmem;
        end
        OSAD_POS_SMALL_AP: begin
          st_nxt.rdata = st_r.small_ap;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end

    // window hits, one per sampled host cycle
    st_nxt.io_hit  = io_cyc & win_open & io_match;
    st_nxt.rom_hit = mem_cyc_i & win_open & rom_match;
    st_nxt.cop_hit = mem_cyc_i & win_open & cop_match;
    st_nxt.ap4_hit = mem_cyc_i & win_open & ap4_en & ap4_match;
    st_nxt.ap1_hit = mem_cyc_i & win_open & ap1_on & ap1_match;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r           <= '0;
      st_r.setup     <= OSAD_SETUP_RESET;
      st_r.rom_inst  <= OSAD_POS_RESET;
      st_r.vmem      <= OSAD_POS_RESET;
      st_r.small_ap  <= OSAD_POS_RESET;
      st_r.rom_base  <= OSAD_ROM_OFFSET;
      st_r.cop_base  <= OSAD_ROM_OFFSET + OSAD_COP_OFFSET;
      st_r.io_base   <= {OSAD_IO_PREFIX, 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign io_rdata_o     = st_r.rdata;
  assign io_rvalid_o    = st_r.rvalid;
  assign io_block_hit_o = st_r.io_hit;
  assign rom_hit_o      = st_r.rom_hit;
  assign cop_hit_o      = st_r.cop_hit;
  assign ap4_hit_o      = st_r.ap4_hit;
  assign ap1_hit_o      = st_r.ap1_hit;
  assign setup_mode_o   = st_r.setup;
  assign rom_base_o     = st_r.rom_base;
  assign cop_base_o     = st_r.cop_base;
  assign io_base_o      = st_r.io_base;
  assign vmem_base_o    = st_r.vmem_base;
  assign ap1_base_o     = st_r.ap1_base;

endmodule

// >>> rtl/osad_pkg.sv
// package: constants of the option-select address decode
package osad_pkg;

  // ----------------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------------
  localparam int unsigned OSAD_IO_AW  = 16;
  localparam int unsigned OSAD_MEM_AW = 32;
  localparam int unsigned OSAD_DW     = 8;

  // ----------------------------------------------------------------------
  // host i/o ports
  // ----------------------------------------------------------------------
  localparam logic [15:0] OSAD_BOARD_SETUP_PORT = 16'h0094;
  localparam logic [7:0]  OSAD_BOARD_SETUP_VAL  = 8'hDF;
  localparam logic [7:0]  OSAD_BOARD_ENABLE_VAL = 8'hFF;
  // option-select bytes seen in setup mode at this base, offset in low 3 bits
  localparam logic [15:0] OSAD_POS_BASE         = 16'h0100;
  localparam logic [2:0]  OSAD_ADAPTER_IDENTIFIER_LO        = 3'h0;
  localparam logic [2:0]  OSAD_ADAPTER_IDENTIFIER_HI        = 3'h1;
  localparam logic [2:0]  OSAD_POS_ROM_INST     = 3'h2;
  localparam logic [2:0]  OSAD_POS_VMEM         = 3'h4;
  localparam logic [2:0]  OSAD_POS_SMALL_AP     = 3'h5;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OSAD_POS_RESET        = 8'h00;
  localparam logic        OSAD_SETUP_RESET      = 1'b0;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned OSAD_ROM_FIELD_LSB    = 4;
  localparam int unsigned OSAD_INST_LSB         = 1;
  localparam int unsigned OSAD_AP4_EN_BIT       = 0;
  localparam int unsigned OSAD_VMEM_FIELD_LSB   = 1;
  localparam int unsigned OSAD_AP1_FIELD_LSB    = 0;

  // ----------------------------------------------------------------------
  // address arithmetic
  // ----------------------------------------------------------------------
  localparam logic [31:0] OSAD_ROM_OFFSET       = 32'h000C0000;
  localparam int unsigned OSAD_ROM_STEP_LSB     = 13;
  localparam logic [31:0] OSAD_COP_OFFSET       = 32'h00001C00;
  localparam int unsigned OSAD_COP_STEP_LSB     = 7;
  localparam logic [7:0]  OSAD_IO_PREFIX        = 8'h21;
  localparam int unsigned OSAD_IO_BLOCK_LSB     = 4;
  localparam int unsigned OSAD_VMEM_REGION_LSB  = 25;
  localparam int unsigned OSAD_VMEM_SLOT_LSB    = 22;
  localparam int unsigned OSAD_AP1_STEP_LSB     = 20;

endpackage

// >>> testbench/osad_decode_assertions.sv
// checker: port-level properties of the option-select address decode
module osad_decode_assertions (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  // host i/o cycle
  input wire logic [15:0] io_addr_i,
  input wire logic        io_wr_i,
  input wire logic        io_rd_i,
  input wire logic [7:0]  io_wdata_i,
  input wire logic [7:0]  io_rdata_o,
  input wire logic        io_rvalid_o,
  // host memory cycle
  input wire logic [31:0] mem_addr_i,
  input wire logic        mem_cyc_i,
  input wire logic        rom_hit_o,
  input wire logic        cop_hit_o,
  input wire logic        ap4_hit_o,
  input wire logic        ap1_hit_o,
  // bases and mode
  input wire logic        setup_mode_o,
  input wire logic [31:0] rom_base_o,
  input wire logic [31:0] cop_base_o,
  input wire logic [15:0] io_base_o,
  input wire logic [31:0] vmem_base_o,
  input wire logic [31:0] ap1_base_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------------------------------------
  // board setup port writes
  // ----------------------------------------------------------------------
  sequence s_enter;
    io_wr_i && io_addr_i == 16'h0094 && io_wdata_i == 8'hDF;
  endsequence
  sequence s_leave;
    io_wr_i && io_addr_i == 16'h0094 && io_wdata_i == 8'hFF;
  endsequence
  a_setup_enter: assert property (s_enter |=> setup_mode_o)
    else $error("setup mode not entered");
  a_setup_leave: assert property (s_leave |=> !setup_mode_o)
    else $error("setup mode not left");
  // ----------------------------------------------------------------------
  // bases, windows and setup read answers
  // ----------------------------------------------------------------------
  a_rom_base: assert property (rom_base_o[31:17] == 15'h0006 && rom_base_o[12:0] == 13'h0000)
    else $error("rom base off grid");
  a_cop_base: assert property (cop_base_o == rom_base_o + 32'h00001C00 + {io_base_o[6:4], 7'h00})
    else $error("coprocessor base wrong");
  a_io_base: assert property (io_base_o[15:7] == 9'h042 && io_base_o[3:0] == 4'h0)
    else $error("io base wrong");
  a_vmem_slot: assert property (vmem_base_o[24:22] == io_base_o[6:4] && vmem_base_o[21:0] == 22'h000000)
    else $error("video slot wrong");
  a_ap4_hit: assert property (ap4_hit_o |-> $past(mem_cyc_i) && $past(mem_addr_i[31:22]) == vmem_base_o[31:22])
    else $error("4MB hit outside aperture");
  a_ap1_hit: assert property (ap1_hit_o |-> ap1_base_o != 32'h00000000 && $past(mem_addr_i[31:20]) == ap1_base_o[31:20])
    else $error("1MB hit wrong");
  a_cop_in_rom: assert property (cop_hit_o |-> rom_hit_o && $past(mem_addr_i[31:7]) == cop_base_o[31:7])
    else $error("coprocessor hit wrong");
  a_setup_quiet: assert property (setup_mode_o |-> !(rom_hit_o || cop_hit_o || ap4_hit_o || ap1_hit_o))
    else $error("hit during setup");
  a_read_answer: assert property (io_rvalid_o |-> $past(io_rd_i) && $past(io_addr_i[15:3]) == 13'h0020)
    else $error("read answer without request");
endmodule

bind osad_decode osad_decode_assertions i_osad_chk (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
  .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .mem_addr_i(mem_addr_i),
  .mem_cyc_i(mem_cyc_i), .rom_hit_o(rom_hit_o), .cop_hit_o(cop_hit_o), .ap4_hit_o(ap4_hit_o),
  .ap1_hit_o(ap1_hit_o), .setup_mode_o(setup_mode_o), .rom_base_o(rom_base_o), .cop_base_o(cop_base_o),
  .io_base_o(io_base_o), .vmem_base_o(vmem_base_o), .ap1_base_o(ap1_base_o));

// >>> testbench/osad_host.sv
// host model: issues i/o cycles on falling edges
module osad_host (
  input  wire logic        sys_clk_i,
  output logic      [15:0] io_addr_o,
  output logic             io_wr_o,
  output logic             io_rd_o,
  output logic      [7:0]  io_wdata_o,
  input  wire logic [7:0]  io_rdata_i,
  input  wire logic        io_rvalid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // no interrupt source here, so setup accesses always run unpreempted
  initial begin
    io_addr_o = 16'hFFFF;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'hFF;
  end
  // released lines show the inverse, so stale values never pass for live ones
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    io_addr_o = a;
    io_wdata_o = d;
    io_wr_o = 1'b1;
    @(negedge sys_clk_i);
    io_wr_o = 1'b0;
    io_addr_o = ~a;
    io_wdata_o = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge sys_clk_i);
    io_addr_o = a;
    io_rd_o = 1'b1;
    @(negedge sys_clk_i);
    // the answer stands only in the cycle after the read edge, so take it here
    d = io_rdata_i;
    v = io_rvalid_i;
    io_rd_o = 1'b0;
    io_addr_o = ~a;
  endtask
endmodule

// >>> testbench/testbench.sv
// testbench: setup-mode access and window decode checks
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // arbitrary identifier value
  localparam logic [15:0] ID_VAL = 16'hC3E7;
  logic        clk, resetn, io_wr, io_rd, io_rvalid, io_hit, mem_cyc, setup, rom_hit, cop_hit, ap4_hit, ap1_hit, v;
  logic [15:0] io_addr, io_base;
  logic [7:0]  io_wdata, io_rdata, d;
  logic [31:0] mem_addr, rom_base, cop_base, vmem_base, ap1_base;
  int          mismatches, checked;
  osad_decode #(.ADAPTER_IDENTIFIER(ID_VAL)) i_osad_decode (
    .sys_clk_i(clk), .resetn_i(resetn), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
    .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .io_rvalid_o(io_rvalid), .io_block_hit_o(io_hit),
    .mem_addr_i(mem_addr), .mem_cyc_i(mem_cyc), .rom_hit_o(rom_hit), .cop_hit_o(cop_hit), .ap4_hit_o(ap4_hit),
    .ap1_hit_o(ap1_hit), .setup_mode_o(setup), .rom_base_o(rom_base), .cop_base_o(cop_base),
    .io_base_o(io_base), .vmem_base_o(vmem_base), .ap1_base_o(ap1_base));
  osad_host i_osad_host (.sys_clk_i(clk), .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd),
    .io_wdata_o(io_wdata), .io_rdata_i(io_rdata), .io_rvalid_i(io_rvalid));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one qualified memory cycle; hits are settled when this returns
  task automatic probe(input logic [31:0] a);
    @(negedge clk);
    mem_addr = a;
    mem_cyc = 1'b1;
    @(negedge clk);
    mem_cyc = 1'b0;
    mem_addr = ~a;
  endtask
  task automatic t_setup;
    cmp(rom_base, 32'h000C0000);
    cmp(cop_base, 32'h000C1C00);
    cmp(io_base, 32'h00002100);
    i_osad_host.wr(16'h0094, 8'h9A);
    cmp(setup, 1'b0);
    i_osad_host.wr(16'h0094, 8'hDF);
    cmp(setup, 1'b1);
    i_osad_host.rd(16'h0100, d, v);
    cmp({v, d}, {1'b1, ID_VAL[7:0]});
    i_osad_host.rd(16'h0101, d, v);
    cmp({v, d}, {1'b1, ID_VAL[15:8]});
  endtask
  // reserved bit 0 of the rom byte is kept clear by the host
  task automatic t_config;
    i_osad_host.wr(16'h0102, 8'hAC);
    i_osad_host.wr(16'h0104, 8'h03);
    i_osad_host.wr(16'h0105, 8'h05);
    repeat (2) @(negedge clk);
    cmp(rom_base, 32'hA * 32'h2000 + 32'h0C0000);
    cmp(cop_base, 32'hD4000 + 32'h1C00 + 32'd128 * 6);
    cmp(io_base, 32'h00002160);
    cmp(vmem_base, (32'd1 << 25) + (32'd6 << 22));
    cmp(ap1_base, 32'd5 * 32'h100000);
    i_osad_host.rd(16'h0102, d, v);
    cmp({v, d}, {1'b1, 8'hAC});
    i_osad_host.rd(16'h0103, d, v);
    cmp({v, d}, {1'b1, 8'h00});
    i_osad_host.wr(16'h0094, 8'hFF);
    cmp(setup, 1'b0);
  endtask
  task automatic t_hits;
    probe(32'h03900000);
    cmp(ap4_hit, 1'b1);
    probe(32'h03BFFFFF);
    cmp(ap4_hit, 1'b1);
    probe(32'h03C00000);
    cmp(ap4_hit, 1'b0);
    probe(32'h00512345);
    cmp(ap1_hit, 1'b1);
    probe(32'h000D5F10);
    cmp({rom_hit, cop_hit}, 2'b11);
    probe(32'h000D5F80);
    cmp({rom_hit, cop_hit}, 2'b10);
    i_osad_host.rd(16'h2165, d, v);
    cmp({io_hit, v}, 2'b10);
  endtask
  task automatic t_off;
    i_osad_host.wr(16'h0094, 8'hDF);
    i_osad_host.wr(16'h0104, 8'h02);
    i_osad_host.wr(16'h0105, 8'h00);
    i_osad_host.wr(16'h0094, 8'hFF);
    probe(32'h03900000);
    cmp(ap4_hit, 1'b0);
    probe(32'h00012345);
    cmp(ap1_hit, 1'b0);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // whole run needs well under 200 cycles
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  initial begin
    resetn = 1'b0;
    mem_cyc = 1'b0;
    mem_addr = 32'h00000000;
    repeat (12) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_setup();
    t_config();
    t_hits();
    t_off();
    finish_test();
  end
endmodule
